// file: design/tdfc_cfg.svh
// Constants for the transceiver data buffer controller
`ifndef TDFC_CFG_SVH
`define TDFC_CFG_SVH
`define TDFC_DEPTH 128
`define TDFC_PTR_W 7
`define TDFC_CNT_W 8
`define TDFC_FIFO_ADDR 8'hFF
`define TDFC_AF_TX_OFFSET 8'h02
`define TDFC_PN9_SEED 9'h1FF
`define TDFC_STAT_FULL_BIT 9
`define TDFC_STAT_EMPTY_BIT 8
`define TDFC_CMD_PREFIX 8'h80
`define TDFC_CMD_ABORT 8'h67
`define TDFC_CMD_FLUSH_RX 8'h71
`define TDFC_CMD_FLUSH_TX 8'h72
`endif

// file: design/tdfc_pkg.sv
// Types for the transceiver data buffer controller
package tdfc_pkg;
  typedef enum logic [1:0] {
    TDFC_SRC_FIFO = 2'h0,
    TDFC_SRC_GPIO = 2'h1,
    TDFC_SRC_PN9 = 2'h2
  } tdfc_src_t;
  typedef enum logic [2:0] {
    TDFC_TX_IDLE = 3'h1,
    TDFC_TX_SEND = 3'h2,
    TDFC_TX_DONE = 3'h4
  } tdfc_txst_t;
endpackage

// file: design/tdfc_top.sv
// Transmit and receive data buffers with thresholds, errors and sources
`timescale 1ns/1ps
`include "tdfc_cfg.svh"

// Function
// - Separate 128-byte transmit and receive buffers.
// - Bus accesses at 0xFF: reads pop receive, writes push transmit.
// - Transmit almost-full flag when free space reaches programmed value minus 2.
// - Transmit almost-empty flag when remaining data reaches low threshold.
// - Receive almost-full flag when free space reaches threshold in bytes.
// - Receive almost-empty flag when remaining data reaches low threshold.
// - Select bit routes receive thresholds when 1, transmit when 0.
// - Overflow and underflow detected per buffer, each raises an error flag.
// - On transmit underflow the last stored byte repeats.
// - Retransmit last packet while retries remain and no new load.
// - Retransmission valid only for packets within 128 bytes.
// - Flush commands empty the respective buffer.
// - Full and empty status on bits 9:8, full if either buffer is full, empty only if both are empty.
// - Sleep keeps buffers only when retentive sleep selected.
// - Buffer mode sends stored bytes unprocessed.
// - GPIO mode outputs data clock, samples input on its rising edge.
// - Test mode sends internal pseudo-random sequence.
// - Buffer receive mode writes incoming bytes continuously.
module tdfc_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Host byte port
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic host_cmd_i,
  input wire logic [7:0] host_cmd_code_i,
  // Configuration
  input wire logic [7:0] tx_free_space_threshold_i,
  input wire logic [7:0] tx_low_level_threshold_i,
  input wire logic [7:0] rx_free_space_threshold_i,
  input wire logic [7:0] rx_low_level_threshold_i,
  input wire logic threshold_irq_select_i,
  input wire logic [3:0] max_retransmissions_i,
  input wire logic [1:0] tx_source_i,
  input wire logic sleep_i,
  input wire logic sleep_retain_i,
  // Radio side
  input wire logic tx_start_i,
  input wire logic [7:0] tx_len_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic gpio_data_i,
  input wire logic link_clk_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic tx_busy_o,
  output logic data_clk_o,
  // Status and events
  output logic [9:8] controller_state_register_o,
  output logic thr_full_o,
  output logic thr_empty_o,
  output logic tx_ovf_o,
  output logic tx_unf_o,
  output logic rx_ovf_o,
  output logic rx_unf_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] tx_mem [0:`TDFC_DEPTH-1];
  logic [7:0] rx_mem [0:`TDFC_DEPTH-1];
  logic [`TDFC_PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp, tx_pkt;
  logic [`TDFC_CNT_W-1:0] tx_cnt, rx_cnt, tx_sent;
  logic [`TDFC_PTR_W-1:0] next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [`TDFC_PTR_W-1:0] next_tx_pkt;
  logic [`TDFC_CNT_W-1:0] next_tx_cnt, next_rx_cnt, next_tx_sent;
  logic [7:0] last_byte, next_last_byte;
  logic [3:0] retx, next_retx;
  logic new_load, next_new_load;
  logic prefix_seen, next_prefix_seen;
  tdfc_pkg::tdfc_txst_t st, next_st;
  // Two-entry output buffer
  logic [7:0] ob_d0, ob_d1, next_ob_d0, next_ob_d1;
  logic [1:0] ob_n, next_ob_n;
  // Link sync and pattern
  logic lk_s0, lk_s1, lk_s2, gd_s0, gd_s1;
  logic [8:0] pn9, next_pn9;
  logic [7:0] sh, next_sh;
  logic [2:0] bitc, next_bitc;
  logic [7:0] rdata, next_rdata;
  logic rval, next_rval;
  logic tfull, tempty, rfull, rempty;
  logic [8:0] flags, next_flags;
  logic [`TDFC_CNT_W-1:0] tx_free, rx_free, p_txc, p_rxc;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic fifo_hit, do_wr, do_rd, cmd_abort, flush_tx, flush_rx, lose;
  logic src_push, src_pop, ob_in_rdy, ob_pop;
  logic [7:0] src_byte;
  assign fifo_hit = host_addr_i == `TDFC_FIFO_ADDR;
  assign do_wr = host_wr_i && fifo_hit;
  assign do_rd = host_rd_i && fifo_hit;
  assign cmd_abort = host_cmd_i && prefix_seen &&
                     host_cmd_code_i == `TDFC_CMD_ABORT;
  // Non-retentive sleep drops both buffers
  assign lose = sleep_i && !sleep_retain_i;
  assign flush_tx = (host_cmd_i && prefix_seen &&
                     host_cmd_code_i == `TDFC_CMD_FLUSH_TX) || lose;
  assign flush_rx = (host_cmd_i && prefix_seen &&
                     host_cmd_code_i == `TDFC_CMD_FLUSH_RX) || lose;
  assign tfull = tx_cnt == 8'(`TDFC_DEPTH);
  assign tempty = tx_cnt == 8'h00;
  assign rfull = rx_cnt == 8'(`TDFC_DEPTH);
  assign rempty = rx_cnt == 8'h00;
  assign tx_free = 8'(`TDFC_DEPTH) - tx_cnt;
  assign rx_free = 8'(`TDFC_DEPTH) - rx_cnt;
  assign ob_in_rdy = ob_n != 2'h2;
  assign ob_pop = ob_n != 2'h0 && tx_ready_i;
  // Link edge found by sampling; clock period must exceed 4 mclk
  logic lk_rise;
  assign lk_rise = lk_s1 && !lk_s2;

  // ----------------------------------------
  // Buffer control
  // ----------------------------------------
  always_comb begin
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    next_tx_cnt = tx_cnt;
    next_rx_cnt = rx_cnt;
    next_tx_sent = tx_sent;
    next_tx_pkt = tx_pkt;
    next_last_byte = last_byte;
    next_retx = retx;
    next_new_load = new_load;
    next_st = st;
    next_rdata = rdata;
    next_rval = do_rd;
    next_prefix_seen = host_cmd_i ? host_cmd_code_i == `TDFC_CMD_PREFIX
                                  : prefix_seen;
    next_flags[3:0] = 4'h0;
    src_pop = 1'b0;
    if (do_wr) begin
      next_tx_wp = tx_wp + 7'h01;
      next_new_load = 1'b1;
      next_last_byte = host_wdata_i;
      if (tfull) begin
        next_flags[0] = 1'b1;
      end else begin
        next_tx_cnt = next_tx_cnt + 8'h01;
      end
    end
    if (do_rd) begin
      next_rdata = rx_mem[rx_rp];
      if (rempty) begin
        next_flags[3] = 1'b1;
      end else begin
        next_rx_rp = rx_rp + 7'h01;
        next_rx_cnt = next_rx_cnt - 8'h01;
      end
    end
    if (rx_valid_i) begin
      if (rfull) begin
        next_flags[2] = 1'b1;
      end else begin
        next_rx_wp = rx_wp + 7'h01;
        next_rx_cnt = next_rx_cnt + 8'h01;
      end
    end
    case (st)
      tdfc_pkg::TDFC_TX_IDLE: begin
        if (tx_start_i) begin
          next_st = tdfc_pkg::TDFC_TX_SEND;
          next_tx_sent = 8'h00;
          next_tx_pkt = tx_rp;
          // A write in the start cycle still counts as a new load
          next_new_load = do_wr;
          next_retx = max_retransmissions_i;
        end
      end
      tdfc_pkg::TDFC_TX_SEND: begin
        if (tx_sent == tx_len_i) begin
          next_st = tdfc_pkg::TDFC_TX_DONE;
        end else if (tx_source_i == 2'(tdfc_pkg::TDFC_SRC_FIFO) &&
                     ob_in_rdy) begin
          src_pop = 1'b1;
          next_tx_sent = tx_sent + 8'h01;
          if (tempty) begin
            next_flags[1] = 1'b1;
          end else begin
            next_tx_rp = tx_rp + 7'h01;
            next_tx_cnt = next_tx_cnt - 8'h01;
          end
        end else if (tx_source_i != 2'(tdfc_pkg::TDFC_SRC_FIFO) &&
                     src_push) begin
          next_tx_sent = tx_sent + 8'h01;
        end
      end
      tdfc_pkg::TDFC_TX_DONE: begin
        // Rewind onto the same bytes; needs packet within the buffer
        if (retx != 4'h0 && !new_load &&
            tx_len_i <= 8'(`TDFC_DEPTH)) begin
          next_retx = retx - 4'h1;
          next_tx_rp = tx_pkt;
          next_tx_cnt = next_tx_cnt + tx_len_i;
          next_tx_sent = 8'h00;
          next_st = tdfc_pkg::TDFC_TX_SEND;
        end else begin
          next_st = tdfc_pkg::TDFC_TX_IDLE;
        end
      end
      default: next_st = tdfc_pkg::TDFC_TX_IDLE;
    endcase
    if (cmd_abort) begin
      next_st = tdfc_pkg::TDFC_TX_IDLE;
    end
    if (flush_tx) begin
      next_tx_wp = 7'h00;
      next_tx_rp = 7'h00;
      next_tx_cnt = 8'h00;
    end
    if (flush_rx) begin
      next_rx_wp = 7'h00;
      next_rx_rp = 7'h00;
      next_rx_cnt = 8'h00;
    end
  end

  // Source byte: buffer, repeated last byte, or serial shifters
  always_comb begin
    src_byte = tempty ? last_byte : tx_mem[tx_rp];
    src_push = src_pop;
    next_sh = sh;
    next_bitc = bitc;
    next_pn9 = pn9;
    if (st == tdfc_pkg::TDFC_TX_SEND &&
        tx_source_i == 2'(tdfc_pkg::TDFC_SRC_GPIO) && lk_rise) begin
      next_sh = {sh[6:0], gd_s1};
      next_bitc = bitc + 3'h1;
      src_push = bitc == 3'h7 && ob_in_rdy;
      src_byte = {sh[6:0], gd_s1};
    end
    if (st == tdfc_pkg::TDFC_TX_SEND &&
        tx_source_i == 2'(tdfc_pkg::TDFC_SRC_PN9) && ob_in_rdy) begin
      next_pn9 = {pn9[7:0], pn9[8] ^ pn9[4]};
      src_push = 1'b1;
      src_byte = pn9[7:0];
    end
  end

  // Output buffer; receiver stall holds the buffer and pattern sources, GPIO bytes arriving in a stall are dropped
  always_comb begin
    next_ob_d0 = ob_d0;
    next_ob_d1 = ob_d1;
    next_ob_n = ob_n;
    if (ob_pop) begin
      next_ob_d0 = ob_d1;
      next_ob_n = ob_n - 2'h1;
    end
    if (src_push) begin
      if (next_ob_n == 2'h0) begin
        next_ob_d0 = src_byte;
      end else begin
        next_ob_d1 = src_byte;
      end
      next_ob_n = next_ob_n + 2'h1;
    end
  end

  // Threshold events on level change, once per reach
  always_comb begin
    next_flags[8:4] = 5'h00;
    next_flags[4] = tx_free != p_txc + 8'h00 && tx_free ==
                    tx_free_space_threshold_i - `TDFC_AF_TX_OFFSET;
    next_flags[5] = tx_cnt != 8'(`TDFC_DEPTH) - p_txc &&
                    tx_cnt == tx_low_level_threshold_i;
    next_flags[6] = rx_free != p_rxc &&
                    rx_free == rx_free_space_threshold_i;
    next_flags[7] = rx_cnt != 8'(`TDFC_DEPTH) - p_rxc &&
                    rx_cnt == rx_low_level_threshold_i;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      tx_mem[tx_wp] <= host_wdata_i;
    end
    if (rx_valid_i && !rfull) begin
      rx_mem[rx_wp] <= rx_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_wp <= 7'h00;
      tx_rp <= 7'h00;
      rx_wp <= 7'h00;
      rx_rp <= 7'h00;
      tx_pkt <= 7'h00;
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
      tx_sent <= 8'h00;
      p_txc <= 8'(`TDFC_DEPTH);
      p_rxc <= 8'(`TDFC_DEPTH);
      last_byte <= 8'h00;
      retx <= 4'h0;
      new_load <= 1'b0;
      prefix_seen <= 1'b0;
      st <= tdfc_pkg::TDFC_TX_IDLE;
      ob_d0 <= 8'h00;
      ob_d1 <= 8'h00;
      ob_n <= 2'h0;
      lk_s0 <= 1'b0;
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      gd_s0 <= 1'b0;
      gd_s1 <= 1'b0;
      pn9 <= `TDFC_PN9_SEED;
      sh <= 8'h00;
      bitc <= 3'h0;
      rdata <= 8'h00;
      rval <= 1'b0;
      flags <= 9'h000;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_busy_o <= 1'b0;
      data_clk_o <= 1'b0;
      controller_state_register_o <= 2'h0;
      host_rdata_o <= 8'h00;
      host_rvalid_o <= 1'b0;
      thr_full_o <= 1'b0;
      thr_empty_o <= 1'b0;
      tx_ovf_o <= 1'b0;
      tx_unf_o <= 1'b0;
      rx_ovf_o <= 1'b0;
      rx_unf_o <= 1'b0;
    end else begin
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      tx_pkt <= next_tx_pkt;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      tx_sent <= next_tx_sent;
      p_txc <= tx_free;
      p_rxc <= rx_free;
      last_byte <= next_last_byte;
      retx <= next_retx;
      new_load <= next_new_load;
      prefix_seen <= next_prefix_seen;
      st <= next_st;
      ob_d0 <= next_ob_d0;
      ob_d1 <= next_ob_d1;
      ob_n <= next_ob_n;
      lk_s0 <= link_clk_i;
      lk_s1 <= lk_s0;
      lk_s2 <= lk_s1;
      gd_s0 <= gpio_data_i;
      gd_s1 <= gd_s0;
      pn9 <= next_pn9;
      sh <= next_sh;
      bitc <= next_bitc;
      rdata <= next_rdata;
      rval <= next_rval;
      flags <= next_flags;
      tx_valid_o <= next_ob_n != 2'h0;
      tx_data_o <= next_ob_d0;
      tx_busy_o <= next_st != tdfc_pkg::TDFC_TX_IDLE;
      data_clk_o <= lk_s1;
      controller_state_register_o <= {tfull | rfull, tempty & rempty};
      host_rdata_o <= rdata;
      host_rvalid_o <= rval;
      // Full pulse with the matching status edge; empty pulse from level events only
      thr_full_o <= threshold_irq_select_i ?
                    (flags[6] | (rfull & ~controller_state_register_o[9])) :
                    (flags[4] | (tfull & ~controller_state_register_o[9]));
      thr_empty_o <= threshold_irq_select_i ? flags[7] : flags[5];
      tx_ovf_o <= flags[0];
      tx_unf_o <= flags[1];
      rx_ovf_o <= flags[2];
      rx_unf_o <= flags[3];
    end
  end
endmodule

// file: bench/tdfc_top_asserts.sv
// Concurrent checks on the buffer controller ports
`timescale 1ns/1ps
`include "tdfc_cfg.svh"
module tdfc_top_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Watched ports
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_rvalid_o,
  input wire logic sleep_i,
  input wire logic sleep_retain_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic [9:8] controller_state_register_o,
  input wire logic thr_full_o,
  input wire logic tx_ovf_o,
  input wire logic rx_unf_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_ff;
  assign rd_ff = host_rd_i && (host_addr_i == `TDFC_FIFO_ADDR);
  AST_RD_ANSWER: assert property (rd_ff |-> ##2 host_rvalid_o)
    else $error("read not answered after two cycles");
  AST_RD_CAUSE: assert property (host_rvalid_o |-> $past(rd_ff, 2))
    else $error("read data without a read");
  // A stalled byte must survive, or the receiver loses it
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o))
    else $error("stalled byte changed");
  AST_RX_UNF: assert property (rd_ff && controller_state_register_o[8]
    && !rx_valid_i |-> ##2 rx_unf_o)
    else $error("empty read without underflow");
  AST_UNF_CAUSE: assert property (rx_unf_o |-> $past(rd_ff, 2))
    else $error("underflow without a read");
  AST_OVF_CAUSE: assert property (tx_ovf_o |-> $past(host_wr_i, 2))
    else $error("overflow without a write");
  AST_THR_ONCE: assert property (thr_full_o |=> !thr_full_o)
    else $error("threshold event repeated");
  AST_STAT_EXCL: assert property (!(&controller_state_register_o))
    else $error("full and empty together");
  AST_SLEEP_DROP: assert property ($rose(sleep_i) && !sleep_retain_i
    |-> ##[1:4] controller_state_register_o[8])
    else $error("plain sleep kept data");
  cover property (rd_ff ##2 host_rvalid_o);
  cover property (tx_valid_o && tx_ready_i);
  cover property (thr_full_o);
  cover property (rx_unf_o);
endmodule

// file: bench/tdfc_radio_model.sv
// Far-side radio model: stalling byte sink and serial bit source
`timescale 1ns/1ps
module tdfc_radio_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Outgoing byte stream
  input wire logic slow_i,
  output logic ready_o,
  // Serial source
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  output logic link_clk_o,
  output logic gpio_o
);
  logic [1:0] cnt = 2'h0;
  initial begin
    ready_o = 1'b0;
    link_clk_o = 1'b0;
    gpio_o = 1'b0;
  end
  // Slow mode takes one byte in four, so the buffer fills
  always @(negedge mclk_i) begin
    cnt <= cnt + 2'h1;
    ready_o <= rst_b_i && (slow_i ? cnt == 2'h0 : cnt != 2'h3);
  end
  // Bit set on the falling link edge, stable at the rising one
  always @(posedge send_i) begin
    #5.3;
    for (int i = 7; i >= 0; i--) begin
      gpio_o = byte_i[i];
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
    end
    gpio_o = ~gpio_o;
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the buffer controller
`timescale 1ns/1ps
`include "tdfc_cfg.svh"
module tb_top;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
  logic host_cmd_i = 1'b0, tx_start_i = 1'b0, rx_valid_i = 1'b0;
  logic [7:0] host_addr_i = 8'hFF, host_wdata_i = 8'h00;
  logic [7:0] host_cmd_code_i = 8'h00, tx_len_i = 8'h00, rx_data_i = 8'h00;
  logic [7:0] tx_free_space_threshold_i = 8'h06;
  logic [7:0] tx_low_level_threshold_i = 8'h02;
  logic [7:0] rx_free_space_threshold_i = 8'h04;
  logic [7:0] rx_low_level_threshold_i = 8'h03;
  logic threshold_irq_select_i = 1'b1, sleep_i = 1'b0;
  logic sleep_retain_i = 1'b0, slow = 1'b0, bit_go = 1'b0, free_tx = 1'b0;
  logic [3:0] max_retransmissions_i = 4'h0;
  logic [1:0] tx_source_i = 2'h0;
  logic [7:0] host_rdata_o, tx_data_o, bit_byte = 8'h00, b, t;
  logic host_rvalid_o, tx_valid_o, tx_ready_i, tx_busy_o, data_clk_o;
  logic link_clk_i, gpio_data_i, thr_full_o, thr_empty_o;
  logic tx_ovf_o, tx_unf_o, rx_ovf_o, rx_unf_o;
  logic [9:8] controller_state_register_o;
  logic [8:0] rxq[$], e;
  logic [7:0] txq[$];
  int err_total = 0, total_checks = 0, n_full = 0, n_empty = 0, n_tx = 0;
  int n_err[4] = '{0, 0, 0, 0};
  always #2 mclk_i = ~mclk_i;
  tdfc_top i_tdfc_top (.mclk_i, .rst_b_i, .host_wr_i, .host_rd_i,
    .host_addr_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o, .host_cmd_i,
    .host_cmd_code_i, .tx_free_space_threshold_i, .tx_low_level_threshold_i,
    .rx_free_space_threshold_i, .rx_low_level_threshold_i,
    .threshold_irq_select_i, .max_retransmissions_i, .tx_source_i, .sleep_i,
    .sleep_retain_i, .tx_start_i, .tx_len_i, .rx_valid_i, .rx_data_i,
    .gpio_data_i, .link_clk_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .tx_busy_o, .data_clk_o, .controller_state_register_o, .thr_full_o,
    .thr_empty_o, .tx_ovf_o, .tx_unf_o, .rx_ovf_o, .rx_unf_o);
  tdfc_radio_model i_tdfc_radio_model (.mclk_i, .rst_b_i, .slow_i(slow),
    .ready_o(tx_ready_i), .send_i(bit_go), .byte_i(bit_byte),
    .link_clk_o(link_clk_i), .gpio_o(gpio_data_i));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task wr(input logic [7:0] d);
    @(negedge mclk_i) {host_wdata_i, host_wr_i} = {d, 1'b1};
    @(negedge mclk_i) host_wr_i = 1'b0;
  endtask
  task drain(input int n);
    repeat (n) begin
      @(negedge mclk_i) host_rd_i = 1'b1;
      @(negedge mclk_i) host_rd_i = 1'b0;
    end
  endtask
  // Commands always go as a prefix byte then the code
  task cmd(input logic [7:0] c);
    @(negedge mclk_i) {host_cmd_code_i, host_cmd_i} = {`TDFC_CMD_PREFIX, 1'b1};
    @(negedge mclk_i) host_cmd_code_i = c;
    @(negedge mclk_i) host_cmd_i = 1'b0;
  endtask
  task fill_rx(input int n, input bit keep);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      @(negedge mclk_i) {rx_data_i, rx_valid_i} = {b, 1'b1};
      @(negedge mclk_i) rx_valid_i = 1'b0;
      if (keep) rxq.push_back({1'b0, b});
    end
  endtask
  task fill_tx(input int n, input bit keep);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      wr(b);
      if (keep) txq.push_back(b);
    end
  endtask
  task pkt(input logic [7:0] len);
    @(negedge mclk_i) {tx_len_i, tx_start_i} = {len, 1'b1};
    @(negedge mclk_i) tx_start_i = 1'b0;
  endtask
  task wait_tx();
    int k;
    k = 0;
    tick(4);
    while ((tx_busy_o !== 1'b0 || txq.size() != 0) && k < 3000) begin
      tick(1);
      k++;
    end
    chk(k < 3000, "transmit did not finish");
  endtask
  // ------------------------------------------------------------
  // Result watcher
  // ------------------------------------------------------------
  always @(posedge mclk_i) begin
    n_full += int'(thr_full_o === 1'b1);
    n_empty += int'(thr_empty_o === 1'b1);
    n_err[0] += int'(tx_ovf_o === 1'b1);
    n_err[1] += int'(tx_unf_o === 1'b1);
    n_err[2] += int'(rx_ovf_o === 1'b1);
    n_err[3] += int'(rx_unf_o === 1'b1);
    if (host_rvalid_o === 1'b1) begin
      e = (rxq.size() == 0) ? 9'h0 : rxq.pop_front();
      chk(e[8] === 1'b1 || host_rdata_o === e[7:0], "read byte");
    end
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      n_tx++;
      t = (txq.size() == 0) ? ~tx_data_o : txq.pop_front();
      if (!free_tx) chk(tx_data_o === t, "transmit byte");
    end
  end
  initial begin
    #200000;
    chk(1'b0, "watchdog expired");
    end_sim();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h536E));
    tick(10);
    rst_b_i = 1'b1;
    tick(2);
    chk(controller_state_register_o === 2'b01, "not empty");
    fill_rx(128, 1'b1);
    tick(3);
    chk(n_full == 2, "rx free-space and full events");
    chk(controller_state_register_o[9] === 1'b1, "rx not full");
    n_empty = 0;
    drain(128);
    tick(4);
    chk(n_empty == 1, "rx low-level event");
    rxq.push_back(9'h100);
    drain(1);
    tick(3);
    chk(n_err[3] == 1, "rx underflow");
    cmd(`TDFC_CMD_ABORT);
    cmd(`TDFC_CMD_FLUSH_RX);
    threshold_irq_select_i = 1'b0;
    n_full = 0;
    fill_rx(129, 1'b0);
    tick(3);
    chk(n_full == 0 && n_err[2] == 1, "rx event routing");
    cmd(`TDFC_CMD_ABORT);
    cmd(`TDFC_CMD_FLUSH_RX);
    tick(3);
    chk(controller_state_register_o === 2'b01, "rx flush");
    n_full = 0;
    fill_tx(129, 1'b0);
    tick(3);
    chk(n_full == 2 && n_err[0] == 1, "tx free-space or overflow");
    cmd(`TDFC_CMD_ABORT);
    cmd(`TDFC_CMD_FLUSH_TX);
    tick(3);
    chk(controller_state_register_o === 2'b01, "tx flush");
    {max_retransmissions_i, slow, n_empty} = {4'h1, 1'b1, 32'h0};
    fill_tx(5, 1'b1);
    for (int i = 0; i < 5; i++) txq.push_back(txq[i]);
    pkt(8'h05);
    wait_tx();
    chk(n_empty > 0, "tx low-level event");
    // No retries left: the new packet goes out exactly once
    max_retransmissions_i = 4'h0;
    fill_tx(5, 1'b1);
    pkt(8'h05);
    wait_tx();
    {max_retransmissions_i, slow} = {4'h0, 1'b0};
    cmd(`TDFC_CMD_FLUSH_TX);
    fill_tx(3, 1'b1);
    txq.push_back(txq[2]);
    txq.push_back(txq[2]);
    pkt(8'h05);
    wait_tx();
    chk(n_err[1] > 0, "tx underflow");
    cmd(`TDFC_CMD_ABORT);
    cmd(`TDFC_CMD_FLUSH_TX);
    fill_rx(2, 1'b1);
    {sleep_retain_i, sleep_i} = 2'b11;
    tick(10);
    sleep_i = 1'b0;
    tick(2);
    drain(2);
    tick(4);
    chk(rxq.size() == 0, "retentive sleep lost data");
    fill_rx(1, 1'b0);
    {sleep_retain_i, sleep_i} = 2'b01;
    tick(4);
    chk(controller_state_register_o[8] === 1'b1, "sleep kept data");
    sleep_i = 1'b0;
    {tx_source_i, bit_byte} = {2'h1, 8'($urandom)};
    txq.push_back(bit_byte);
    pkt(8'h01);
    bit_go = 1'b1;
    tick(1);
    bit_go = 1'b0;
    wait_tx();
    {tx_source_i, free_tx, n_tx} = {2'h2, 1'b1, 32'h0};
    pkt(8'h02);
    wait_tx();
    chk(n_tx >= 2, "test pattern bytes");
    end_sim();
  end
endmodule
bind tdfc_top tdfc_top_asserts i_tdfc_top_asserts (.mclk_i, .rst_b_i,
  .host_wr_i, .host_rd_i, .host_addr_i, .host_rvalid_o, .sleep_i,
  .sleep_retain_i, .rx_valid_i, .tx_ready_i, .tx_valid_o, .tx_data_o,
  .controller_state_register_o, .thr_full_o, .tx_ovf_o, .rx_unf_o);
